// File: inc/strap_led_pkg.sv
// Package with constants for the strap latch and status indicator block
package strap_led_pkg;
  // AXI4-Lite response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0] STRAP_STATUS_OFS = 8'h00;
  localparam logic [7:0] LINK_CTRL_OFS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'hFC;
  // Strap status fields
  localparam int STS_REGDIS_BIT = 0;
  localparam int STS_IRQSEL_BIT = 1;
  localparam int STS_IFMODE_BIT = 2;
  localparam int STS_ADDR_LSB = 4;
  localparam int STS_LATCHED_BIT = 8;
  // Link control fields
  localparam int CTL_LINK_BIT = 0;
  localparam int CTL_SPEED100_BIT = 1;
  localparam int CTL_ISOLATE_BIT = 2;
  localparam int CTL_ACTIVITY_BIT = 3;
  localparam int CTL_IRQ_BIT = 4;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
  // Last settle count before straps are captured; covers synchroniser and filter
  localparam logic [2:0] SETTLE_LAST = 3'h5;
  // LED active level (high drives the lamp)
  localparam logic LED_ON = 1'b1;
  localparam logic LED_OFF = 1'b0;
endpackage

// File: logic/strap_latch_and_status_leds.sv
// Strap capture at reset, pin function select and status indicator drive
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Sample straps at every reset, hold them
// - External reset is active low, re-latches straps
// - Link indicator on with link, blinks on traffic
// - Speed indicator on only at 100 Mb/s
// - Interrupt strap selects irq or tx-error function
// - Regulator disabled when its strap is high
// - Management clock input, bidirectional data pin
// - Management address from three latched straps
// - Interface strap selects MII low, RMII high
module strap_latch_and_status_leds
  import strap_led_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  // Strap pins, sensed while they are inputs
  input wire logic regulator_disable_strap,
  input wire logic irq_pin_function_strap,
  input wire logic interface_mode_strap,
  input wire logic [2:0] mgmt_address_straps,
  // Shared LED pins: output and enable
  output logic link_activity_indicator,
  output logic link_activity_indicator_oe,
  output logic link_speed_indicator,
  output logic link_speed_indicator_oe,
  // Multiplexed interrupt / transmit error pin
  output logic irq_out_n,
  output logic irq_out_oe,
  input wire logic tx_error_input,
  output logic tx_error_seen,
  output logic tx_symbol_bit4,
  // Management interface pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mgmt_drive,
  input wire logic mgmt_data,
  output logic mdc_sync,
  output logic mdio_sync,
  // Configuration results
  output logic regulator_enable,
  output logic rmii_mode,
  output logic [2:0] mgmt_address,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Combined reset: either the system reset or the external pin
  logic sys_rst_n;
  assign sys_rst_n = rst_n & external_reset_n;

  // Three-stage synchronisers for pin inputs; stage 1 feeds only stage 2
  logic [8:0] s1_q, s2_q, s3_q;
  logic [8:0] pins;
  assign pins = {mdc_in, mdio_in, tx_error_input, mgmt_address_straps, interface_mode_strap,
                 irq_pin_function_strap, regulator_disable_strap};
  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      s3_q <= 9'h000;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered pin level: changes only when stages two and three agree
  logic [8:0] flt_q, flt_d;
  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < 9; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flt_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      flt_q <= 9'h000;
    end else begin
      flt_q <= flt_d;
    end
  end

  // Strap latch: a settle counter waits for the filter, then captures once
  logic [2:0] settle_q, settle_d;
  logic latched_q, latched_d;
  logic [5:0] straps_q, straps_d; // {addr[2:0], ifmode, irq select, regulator disable}
  always_comb begin
    settle_d = settle_q;
    latched_d = latched_q;
    straps_d = straps_q;
    if (!latched_q) begin
      // Wait for three synchroniser stages plus filter before trusting the level
      if (settle_q != SETTLE_LAST) begin
        settle_d = settle_q + 3'h1;
      end else begin
        straps_d = flt_q[5:0];
        latched_d = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      settle_q <= 3'h0;
      latched_q <= 1'b0;
      straps_q <= 6'h00; // Pull-down defaults until captured
    end else begin
      settle_q <= settle_d;
      latched_q <= latched_d;
      straps_q <= straps_d;
    end
  end

  // Register file: link state written by software stands in for the PHY core
  logic [31:0] ctrl_q, ctrl_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] status_w;

  // Read value of the strap status register
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[STS_REGDIS_BIT] = straps_q[0];
    status_w[STS_IRQSEL_BIT] = straps_q[1];
    status_w[STS_IFMODE_BIT] = straps_q[2];
    status_w[STS_ADDR_LSB +: 3] = straps_q[5:3];
    status_w[STS_LATCHED_BIT] = latched_q;
  end

  // Byte-lane merge, used for the control register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write and read channel handling; address and data accepted in either order
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    ctrl_d = ctrl_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_awvalid && !aw_q && !bv_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (aw_q && w_q) begin
      // Both halves held: perform the write and answer
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      if ((awa_q & ADDR_MASK) == LINK_CTRL_OFS) begin
        ctrl_d = merge(ctrl_q, wd_q, ws_q);
        br_d = RESP_OKAY;
      end else if ((awa_q & ADDR_MASK) == STRAP_STATUS_OFS) begin
        br_d = RESP_OKAY; // Read-only: write ignored
      end else begin
        br_d = RESP_SLVERR; // Unmapped address
      end
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      if ((s_axi_araddr & ADDR_MASK) == STRAP_STATUS_OFS) begin
        rd_d = status_w;
        rr_d = RESP_OKAY;
      end else if ((s_axi_araddr & ADDR_MASK) == LINK_CTRL_OFS) begin
        rd_d = ctrl_q;
        rr_d = RESP_OKAY;
      end else begin
        rd_d = 32'h0000_0000;
        rr_d = RESP_SLVERR;
      end
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end
  // Bus registers follow rst_n only, so a pin reset does not break a transfer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= RESP_OKAY;
      ctrl_q <= LINK_CTRL_RESET;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= RESP_OKAY;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      ctrl_q <= ctrl_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end
  // Ready is offered only while the slot is empty
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  // Blink timer for activity; free-running while traffic is flagged
  logic [$clog2(BLINK_CYCLES+1)-1:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  always_comb begin
    blink_cnt_d = blink_cnt_q;
    blink_d = blink_q;
    if (!ctrl_q[CTL_ACTIVITY_BIT]) begin
      blink_cnt_d = '0;
      blink_d = 1'b0;
    end else if (blink_cnt_q == $bits(blink_cnt_q)'(BLINK_CYCLES - 1)) begin
      blink_cnt_d = '0;
      blink_d = !blink_q;
    end else begin
      blink_cnt_d = blink_cnt_q + 1'b1;
    end
  end

  // Output stage: LEDs, pin enables, decoded configuration
  logic lnk_d, spd_d, oe_d, irq_n_d, irq_oe_d, txe_d, sym4_d, mo_d, moe_d;
  logic lnk_q, spd_q, oe_q, irq_n_q, irq_oe_q, txe_q, sym4_q, mo_q, moe_q;
  logic reg_en_q, rmii_q, mdc_q, mdio_q;
  logic [2:0] addr_q;
  always_comb begin
    lnk_d = LED_OFF;
    spd_d = LED_OFF;
    oe_d = latched_q;
    irq_n_d = 1'b1;
    irq_oe_d = 1'b0;
    txe_d = 1'b0;
    sym4_d = 1'b0;
    mo_d = 1'b0;
    moe_d = 1'b0;
    if (latched_q) begin
      // Link lit steady, dark phase of blink during traffic
      if (ctrl_q[CTL_LINK_BIT]) begin
        lnk_d = blink_q ? LED_OFF : LED_ON;
      end
      // Speed lamp dark at 10 Mb/s and while isolated
      if (ctrl_q[CTL_SPEED100_BIT] && !ctrl_q[CTL_ISOLATE_BIT]) begin
        spd_d = LED_ON;
      end
      if (straps_q[1]) begin
        // Strap high or floating: open-drain interrupt, drives only when low
        irq_n_d = !ctrl_q[CTL_IRQ_BIT];
        irq_oe_d = ctrl_q[CTL_IRQ_BIT];
      end else begin
        // Strap low: pin is an input feeding tx error or symbol bit 4
        txe_d = flt_q[6] & !ctrl_q[CTL_SPEED100_BIT];
        sym4_d = flt_q[6] & ctrl_q[CTL_SPEED100_BIT];
      end
      // Data pin is open-drain; engine asks to pull low
      moe_d = mgmt_drive & !mgmt_data;
    end
  end
  always_ff @(posedge sys_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      lnk_q <= LED_OFF;
      spd_q <= LED_OFF;
      oe_q <= 1'b0;
      irq_n_q <= 1'b1;
      irq_oe_q <= 1'b0;
      txe_q <= 1'b0;
      sym4_q <= 1'b0;
      mo_q <= 1'b0;
      moe_q <= 1'b0;
      reg_en_q <= 1'b1;
      rmii_q <= 1'b0;
      addr_q <= 3'h0;
      mdc_q <= 1'b0;
      mdio_q <= 1'b0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      lnk_q <= lnk_d;
      spd_q <= spd_d;
      oe_q <= oe_d;
      irq_n_q <= irq_n_d;
      irq_oe_q <= irq_oe_d;
      txe_q <= txe_d;
      sym4_q <= sym4_d;
      mo_q <= mo_d;
      moe_q <= moe_d;
      reg_en_q <= !straps_q[0];
      rmii_q <= straps_q[2];
      addr_q <= straps_q[5:3];
      mdc_q <= flt_q[8];
      mdio_q <= flt_q[7];
    end
  end
  assign link_activity_indicator = lnk_q;
  assign link_speed_indicator = spd_q;
  assign link_activity_indicator_oe = oe_q;
  assign link_speed_indicator_oe = oe_q;
  assign irq_out_n = irq_n_q;
  assign irq_out_oe = irq_oe_q;
  assign tx_error_seen = txe_q;
  assign tx_symbol_bit4 = sym4_q;
  assign mdio_out = mo_q;
  assign mdio_oe = moe_q;
  assign regulator_enable = reg_en_q;
  assign rmii_mode = rmii_q;
  assign mgmt_address = addr_q;
  assign mdc_sync = mdc_q;
  assign mdio_sync = mdio_q;

endmodule
`default_nettype wire

// File: tb/board_model.sv
// Board side: strap resistors, lamps, reset button, management master
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input wire logic sys_clk,
  input wire logic [5:0] strap_level,
  input wire logic reset_press,
  input wire logic mgmt_frame,
  input wire logic link_activity_indicator,
  input wire logic link_activity_indicator_oe,
  input wire logic link_speed_indicator,
  input wire logic link_speed_indicator_oe,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic regulator_disable_strap,
  output logic irq_pin_function_strap,
  output logic interface_mode_strap,
  output logic [2:0] mgmt_address_straps,
  output logic external_reset_n,
  output logic mdc_in,
  output logic mdio_in
);
  logic [1:0] div_q = 2'h0; // Clock divider: two system cycles per clock phase
  // Shared lamp pins show the lamp once driven, else the resistor
  assign regulator_disable_strap = link_activity_indicator_oe ? link_activity_indicator : strap_level[0];
  assign irq_pin_function_strap = link_speed_indicator_oe ? link_speed_indicator : strap_level[1];
  assign interface_mode_strap = strap_level[2];
  assign mgmt_address_straps = strap_level[5:3];
  // Button pulls the reset line low
  assign external_reset_n = !reset_press;
  // Data line has a pull-up; clock stands still outside frames
  assign mdio_in = !(mdio_oe && !mdio_out);
  // Phases two cycles long so the three-stage pin filter can follow the clock
  always @(posedge sys_clk) div_q <= mgmt_frame ? div_q + 2'h1 : 2'h0;
  assign mdc_in = div_q[1];
endmodule
`default_nettype wire

// File: tb/strap_led_monitor.sv
// Checker for strap capture, indicator pins and read timing
`timescale 1ns/1ps
`default_nettype none
module strap_led_monitor #(
  parameter int BLINK_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic external_reset_n,
  input wire logic regulator_disable_strap,
  input wire logic link_activity_indicator_oe,
  input wire logic link_speed_indicator_oe,
  input wire logic irq_out_n,
  input wire logic irq_out_oe,
  input wire logic regulator_enable,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // One clock; bus reset silences every check
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_dark_in_reset: assert property (!external_reset_n |-> !link_activity_indicator_oe && !link_speed_indicator_oe)
    else $error("lamp pin driven in reset");
  a_irq_idle_reset: assert property (!external_reset_n |-> irq_out_n)
    else $error("irq pin active in reset");
  // Straps need settle time, so lamps stay inputs a while
  a_latch_delay: assert property ($rose(external_reset_n) |->
    !link_speed_indicator_oe [*5] ##[1:5] link_speed_indicator_oe) else $error("capture out of time");
  a_config_hold: assert property (link_activity_indicator_oe && $past(link_activity_indicator_oe)
    |-> $stable(regulator_enable)) else $error("latched config moved");
  // Before the pin turns round it still shows the resistor
  a_regulator_cap: assert property ($rose(link_activity_indicator_oe)
    |-> regulator_enable == !$past(regulator_disable_strap)) else $error("regulator enable wrong");
  a_irq_drain: assert property (irq_out_oe == !irq_out_n)
    else $error("irq pin not open drain");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not cleared");
  cover property ($rose(link_speed_indicator_oe));
  cover property (!irq_out_n);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind strap_latch_and_status_leds strap_led_monitor #(.BLINK_CYCLES(BLINK_CYCLES)) mon_i (
  .sys_clk, .rst_n, .external_reset_n, .regulator_disable_strap, .link_activity_indicator_oe,
  .link_speed_indicator_oe, .irq_out_n, .irq_out_oe, .regulator_enable,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// File: tb/tb_strap_latch_and_status_leds.sv
// Self-checking bench for strap capture, lamps and registers
`timescale 1ns/1ps
`default_nettype none
module tb_strap_latch_and_status_leds import strap_led_pkg::*;;
  localparam int BLINK = 4;
  logic sys_clk = 1'b0, rst_n = 1'b0, reset_press = 1'b0, mgmt_frame = 1'b0;
  logic tx_error_input = 1'b0, mgmt_drive = 1'b0, mgmt_data = 1'b0;
  logic [5:0] strap_level = 6'h00;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic link_activity_indicator, link_activity_indicator_oe, link_speed_indicator, link_speed_indicator_oe;
  logic irq_out_n, irq_out_oe, tx_symbol_bit4, mdio_out, mdio_oe, regulator_enable, rmii_mode;
  logic tx_error_seen, mdc_sync, mdio_sync;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic regulator_disable_strap, irq_pin_function_strap, interface_mode_strap, external_reset_n, mdc_in, mdio_in;
  logic [2:0] mgmt_address, mgmt_address_straps;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [31:0] tbl[4] = '{32'h1, 32'h3, 32'h7, 32'h2};
  integer failures = 0, check_count = 0, cycles = 0, seed = 32'h0E04, n;
  logic lvl;

  strap_latch_and_status_leds #(.BLINK_CYCLES(BLINK)) strap_latch_and_status_leds_i (
    .sys_clk, .rst_n, .external_reset_n, .regulator_disable_strap, .irq_pin_function_strap, .interface_mode_strap,
    .mgmt_address_straps, .link_activity_indicator, .link_activity_indicator_oe, .link_speed_indicator,
    .link_speed_indicator_oe, .irq_out_n, .irq_out_oe, .tx_error_input, .tx_error_seen, .tx_symbol_bit4,
    .mdc_in, .mdio_in, .mdio_out, .mdio_oe, .mgmt_drive, .mgmt_data, .mdc_sync, .mdio_sync, .regulator_enable,
    .rmii_mode, .mgmt_address, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  board_model board_model_i (
    .sys_clk, .strap_level, .reset_press, .mgmt_frame, .link_activity_indicator, .link_activity_indicator_oe,
    .link_speed_indicator, .link_speed_indicator_oe, .mdio_out, .mdio_oe, .regulator_disable_strap,
    .irq_pin_function_strap, .interface_mode_strap, .mgmt_address_straps, .external_reset_n, .mdc_in, .mdio_in
  );

  always #25 sys_clk = !sys_clk;

  task automatic finish_test();
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Cut a hang short well past the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  // Each answer taken off the bus meets the oldest expectation
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
  end

  // Address and data offered together; bready waits up front
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wr_q.push_back(r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Ready offered with the address and held until the answer is sampled
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic done;
    rd_q.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end while (!done);
    s_axi_rready <= 1'b0;
  endtask

  // Pulse the pin reset with new straps, then confirm the capture
  task automatic press(input logic [5:0] s);
    @(posedge sys_clk);
    reset_press <= 1'b1;
    strap_level <= s;
    repeat (2) @(posedge sys_clk);
    chk({28'h0, link_activity_indicator_oe, link_speed_indicator_oe, link_activity_indicator,
         link_speed_indicator, irq_out_oe, regulator_enable}, 34'h1);
    reset_press <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rd(STRAP_STATUS_OFS, {RESP_OKAY, 23'h0, 1'b1, 1'b0, s[5:3], 1'b0, s[2:0]});
    chk({29'h0, regulator_enable, rmii_mode, mgmt_address}, {29'h0, !s[0], s[2], s[5:3]});
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rd(STRAP_STATUS_OFS, {RESP_OKAY, 32'h100});
    for (int i = 0; i < 4; i++) press(i == 1 ? 6'h3F : 6'($random(seed)));
    press(6'h02);
    // Link, speed and isolation combinations against both lamps
    foreach (tbl[k]) begin
      wr(LINK_CTRL_OFS, tbl[k], RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      chk({32'h0, link_activity_indicator, link_speed_indicator}, {32'h0, tbl[k][0], tbl[k][1] && !tbl[k][2]});
      rd(LINK_CTRL_OFS, {RESP_OKAY, tbl[k]});
    end
    // Traffic makes the link lamp toggle once per blink count
    wr(LINK_CTRL_OFS, 32'h9, RESP_OKAY);
    repeat (2) begin
      lvl = link_activity_indicator;
      n = 0;
      while (link_activity_indicator === lvl && n < 40) begin
        @(posedge sys_clk);
        n++;
      end
    end
    chk(34'(n), 34'(BLINK));
    wr(LINK_CTRL_OFS, 32'h11, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk({33'h0, irq_out_n}, 34'h0);
    wr(STRAP_STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(STRAP_STATUS_OFS, {RESP_OKAY, 32'h102});
    wr(8'h0C, 32'h0, RESP_SLVERR);
    rd(8'h08, {RESP_SLVERR, 32'h0});
    // Data pin pulled low only when the device sends a zero
    mgmt_frame <= 1'b1;
    mgmt_drive <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk);
      mgmt_data <= 1'($random(seed));
      // Pin follows after one register, its synced copy after the filter
      repeat (7) @(posedge sys_clk);
      chk({32'h0, mdio_in, mdio_sync}, {32'h0, mgmt_data, mgmt_data});
    end
    // Synced clock copy keeps the two-cycle phases of the board clock
    lvl = mdc_sync;
    repeat (2) @(posedge sys_clk);
    chk({33'h0, mdc_sync}, {33'h0, !lvl});
    mgmt_drive <= 1'b0;
    mgmt_frame <= 1'b0;
    // Strap low makes the pin an input, seen as symbol bit 4 at 100 Mb/s, so no interrupt
    press(6'h00);
    wr(LINK_CTRL_OFS, 32'h13, RESP_OKAY);
    tx_error_input <= 1'b1;
    repeat (7) @(posedge sys_clk);
    chk({30'h0, irq_out_n, irq_out_oe, tx_symbol_bit4, tx_error_seen}, 34'hA);
    // At 10 Mb/s the same input shows up as transmit error instead
    wr(LINK_CTRL_OFS, 32'h1, RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, irq_out_n, irq_out_oe, tx_symbol_bit4, tx_error_seen}, 34'h9);
    finish_test();
  end
endmodule
`default_nettype wire
